// ### rtl/flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;
  // flash command bytes
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] CMD_PROG_SETUP_B = 8'h10;
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  // flash status bit positions
  localparam int ST_READY_BIT   = 7;
  localparam int ST_SUSP_BIT    = 6;
  localparam int ST_ERASE_BIT   = 5;
  localparam int ST_PROG_BIT    = 4;
  localparam int ST_SUPPLY_BIT  = 3;
  // wishbone register byte offsets
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_ADDR    = 4'h4;
  localparam logic [3:0] REG_DATA    = 4'h8;
  localparam logic [3:0] REG_STATUS  = 4'hC;
  // control register fields
  localparam int CTRL_OP_LSB     = 0;
  localparam int CTRL_GO_BIT     = 4;
  localparam int CTRL_RESET_BIT  = 5;
  localparam int CTRL_WP_BIT     = 6;
  // host operations
  localparam logic [3:0] OP_PROGRAM  = 4'h1;
  localparam logic [3:0] OP_READ     = 4'h2;
  localparam logic [3:0] OP_STATUS   = 4'h3;
  localparam logic [3:0] OP_CLEAR    = 4'h4;
  localparam logic [3:0] OP_ABORT    = 4'h5;
  // bus timing in cycles of the 40 MHz clock
  localparam int CLK_NS        = 25;
  localparam int STROBE_NS     = 100;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int POLL_LIMIT    = 65535;
endpackage
`default_nettype wire

// ### rtl/strobe_timer.sv
`default_nettype none
module strobe_timer
  import flash_host_pkg::*;
#(
  parameter int CYCLES = STROBE_CYC
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  input  wire logic clk_en_in,
  // control
  input  wire logic start_in,
  output logic      done_out
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       run;
  } tmr_t;
  tmr_t st_r, st_nxt;

  always_comb begin
    st_nxt   = st_r;
    done_out = st_r.run && (st_r.cnt == 8'h00);
    if (start_in) begin
      st_nxt.run = 1'b1;
      st_nxt.cnt = 8'(CYCLES - 1);
    end else if (st_r.run) begin
      if (st_r.cnt == 8'h00) st_nxt.run = 1'b0;
      else st_nxt.cnt = st_r.cnt - 8'h01;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) st_r <= '0;
    else if (clk_en_in) st_r <= st_nxt;
  end
endmodule // strobe_timer
`default_nettype wire

// ### rtl/status_decode.sv
`default_nettype none
module status_decode
  import flash_host_pkg::*;
(
  // status byte sampled from the flash
  input  wire logic [7:0] status_in,
  // decoded flags
  output logic            ready_out,
  output logic            suspended_out,
  output logic            any_error_out,
  output logic [2:0]      errors_out
);
  assign ready_out     = status_in[ST_READY_BIT];
  assign suspended_out = status_in[ST_SUSP_BIT];
  assign errors_out    = {status_in[ST_ERASE_BIT], status_in[ST_PROG_BIT], status_in[ST_SUPPLY_BIT]};
  assign any_error_out = |errors_out;
endmodule // status_decode
`default_nettype wire

// ### rtl/flash_program_status_control.sv
`default_nettype none
module flash_program_status_control
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // clock, reset, enable
  input  wire logic              ref_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              clk_en_in,
  // wishbone slave
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [3:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic [31:0]            wb_dat_out,
  output logic                   wb_ack_out,
  // flash pins
  output logic                   chip_sel_n_out,
  output logic                   out_en_n_out,
  output logic                   wr_strobe_n_out,
  output logic                   reset_powerdown_n_out,
  output logic                   write_protect_n_out,
  output logic [ADDR_W-1:0]      flash_addr_out,
  input  wire logic [7:0]        flash_dq_in,
  output logic [7:0]             flash_dq_out,
  output logic                   flash_dq_oe_out
);
  typedef enum logic [3:0] {
    S_IDLE, S_WR_LOW, S_WR_HIGH, S_RD_LOW, S_RD_HIGH, S_POLL_GAP
  } phase_t;

  // all block state except the strobe timer count in one record; one comb process builds the next copy
  typedef enum logic [2:0] {
    K_NONE, K_SETUP, K_PDATA, K_POLL, K_CMD, K_READ
  } step_t;

  typedef struct packed {
    phase_t            phase;
    step_t             step;
    logic [3:0]        op;
    logic              busy;
    logic              timeout;
    logic              rst_pin;
    logic              wp_pin;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic [7:0]        status;
    logic [7:0]        bus_byte;
    logic [15:0]       polls;
    logic              ack;
    logic [31:0]       wb_rd;
    logic              cs_n;
    logic              oe_n;
    logic              we_n;
    logic              dq_oe;
  } state_t;

  state_t st_r, st_nxt;
  logic   tmr_start;
  logic   tmr_done;
  logic   st_ready;
  logic   st_any_err;

  // one timer paces every phase except S_IDLE and the unused S_RD_HIGH; phases follow each other and never overlap
  strobe_timer #(.CYCLES(STROBE_CYC)) u_timer (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .clk_en_in  (clk_en_in),
    .start_in   (tmr_start),
    .done_out   (tmr_done)
  );

  status_decode u_decode (
    .status_in     (st_r.status),
    .ready_out     (st_ready),
    .suspended_out (),
    .any_error_out (st_any_err),
    .errors_out    ()
  );

  // start a bus write: one strobe with cs and we low, oe held high
  function automatic state_t begin_write(input state_t s, input logic [7:0] b, input step_t k);
    state_t t;
    t          = s;
    t.bus_byte = b;
    t.step     = k;
    t.phase    = S_WR_LOW;
    t.cs_n     = 1'b0;
    t.oe_n     = 1'b1;
    t.we_n     = 1'b0;
    t.dq_oe    = 1'b1;
    return t;
  endfunction

  function automatic state_t begin_read(input state_t s, input step_t k);
    state_t t;
    t       = s;
    t.step  = k;
    t.phase = S_RD_LOW;
    // the data driver lets go in the same edge at which output enable falls
    t.we_n  = 1'b1;
    t.dq_oe = 1'b0;
    t.cs_n  = 1'b0;
    t.oe_n  = 1'b0;
    return t;
  endfunction

  always_comb begin
    st_nxt    = st_r;
    tmr_start = 1'b0;
    st_nxt.ack = 1'b0;
    // register access; ack one cycle after the request, dropped next cycle
    if (wb_cyc_in && wb_stb_in && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      unique case (wb_adr_in)
        REG_CTRL: st_nxt.wb_rd = {24'h00_0000, st_r.wp_pin, st_r.rst_pin, st_r.busy, 1'b0, st_r.op};
        REG_ADDR: st_nxt.wb_rd = 32'(st_r.addr);
        REG_DATA: st_nxt.wb_rd = {24'h00_0000, st_r.rdata};
        REG_STATUS: st_nxt.wb_rd = {22'h00_0000, st_r.timeout, st_any_err, st_r.status};
        default: st_nxt.wb_rd = 32'h0000_0000;
      endcase
      if (wb_we_in && wb_sel_in[0]) begin
        unique case (wb_adr_in)
          REG_CTRL: begin
            st_nxt.rst_pin = wb_dat_in[CTRL_RESET_BIT];
            st_nxt.wp_pin  = wb_dat_in[CTRL_WP_BIT];
            if (wb_dat_in[CTRL_GO_BIT] && !st_r.busy) begin
              st_nxt.op      = wb_dat_in[CTRL_OP_LSB +: 4];
              st_nxt.busy    = 1'b1;
              st_nxt.timeout = 1'b0;
            end
            // pulling reset/power-down low kills any sequence; flash clears its status
            if (!wb_dat_in[CTRL_RESET_BIT]) begin
              st_nxt.status = 8'h00;
            end
          end
          // address or data moving under a live strobe would corrupt the flash cycle
          REG_ADDR: begin
            if (!st_r.busy) st_nxt.addr = wb_dat_in[ADDR_W-1:0];
          end
          REG_DATA: begin
            if (!st_r.busy) st_nxt.wdata = wb_dat_in[7:0];
          end
          default: ;
        endcase
      end
    end

    unique case (st_r.phase)
      S_IDLE: begin
        if (st_r.busy && st_r.step == K_NONE) begin
          unique case (st_r.op)
            OP_PROGRAM, OP_ABORT: begin
              // abort shares the set-up write; the all-ones byte then replaces the data
              st_nxt = begin_write(st_nxt, CMD_PROG_SETUP, K_SETUP);
            end
            OP_READ:    st_nxt = begin_write(st_nxt, CMD_READ_ARRAY, K_READ);
            OP_STATUS:  st_nxt = begin_write(st_nxt, CMD_READ_STATUS, K_POLL);
            OP_CLEAR:   st_nxt = begin_write(st_nxt, CMD_CLEAR_STATUS, K_CMD);
            default: begin
              st_nxt.busy = 1'b0;
            end
          endcase
          st_nxt.polls = 16'h0000;
          tmr_start = (st_nxt.phase == S_WR_LOW);
        end
      end
      S_WR_LOW: if (tmr_done) begin
        st_nxt.we_n  = 1'b1; // rising edge latches address and data
        st_nxt.phase = S_WR_HIGH;
        tmr_start    = 1'b1;
      end
      S_WR_HIGH: if (tmr_done) begin
        // chip select stays low only where the next strobe follows at once
        st_nxt.cs_n  = 1'b1;
        st_nxt.dq_oe = 1'b0;
        unique case (st_r.step)
          K_SETUP: begin
            // abort variant writes all-ones instead of data
            if (st_r.op == OP_ABORT) st_nxt = begin_write(st_nxt, CMD_READ_ARRAY, K_CMD);
            else st_nxt = begin_write(st_nxt, st_r.wdata, K_PDATA);
            tmr_start = 1'b1;
          end
          K_PDATA, K_POLL: begin
            st_nxt    = begin_read(st_nxt, K_POLL);
            tmr_start = 1'b1;
          end
          K_READ: begin
            st_nxt    = begin_read(st_nxt, K_READ);
            tmr_start = 1'b1;
          end
          default: begin
            st_nxt.phase = S_IDLE;
            st_nxt.step  = K_NONE;
            st_nxt.busy  = 1'b0;
          end
        endcase
      end
      S_RD_LOW: if (tmr_done) begin
        // data is taken at the end of the strobe, long after the flash output settled
        if (st_r.step == K_POLL) st_nxt.status = flash_dq_in;
        else st_nxt.rdata = flash_dq_in;
        st_nxt.cs_n  = 1'b1;
        st_nxt.oe_n  = 1'b1; // toggled off between status reads
        st_nxt.phase = S_POLL_GAP;
        tmr_start    = 1'b1;
      end
      S_POLL_GAP: if (tmr_done) begin
        if (st_r.step == K_POLL && !st_ready) begin
          // a flash that never reports ready would otherwise hold the block busy forever
          if (st_r.polls == 16'(POLL_LIMIT)) begin
            st_nxt.timeout = 1'b1;
            st_nxt.phase = S_IDLE;
            st_nxt.step  = K_NONE;
            st_nxt.busy  = 1'b0;
          end else begin
            st_nxt.polls = st_r.polls + 16'h0001;
            st_nxt       = begin_read(st_nxt, K_POLL);
            tmr_start    = 1'b1;
          end
        end else begin
          // error bits in the captured status are left for software
          st_nxt.phase = S_IDLE;
          st_nxt.step  = K_NONE;
          st_nxt.busy  = 1'b0;
        end
      end
      default: st_nxt.phase = S_IDLE;
    endcase

    // placed last so that power-down overrides whatever step the phase logic chose
    if (!st_r.rst_pin) begin
      st_nxt.phase = S_IDLE;
      st_nxt.step  = K_NONE;
      st_nxt.busy  = 1'b0;
      st_nxt.cs_n  = 1'b1;
      st_nxt.oe_n  = 1'b1;
      st_nxt.we_n  = 1'b1;
      st_nxt.dq_oe = 1'b0;
      tmr_start    = 1'b0;
    end
  end

  // pins leave reset idle with reset/power-down high, so the flash starts in read array
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r         <= '0;
      st_r.phase   <= S_IDLE;
      st_r.step    <= K_NONE;
      st_r.rst_pin <= 1'b1;
      st_r.wp_pin  <= 1'b0; // boot sector locked by default
      st_r.cs_n    <= 1'b1;
      st_r.oe_n    <= 1'b1;
      st_r.we_n    <= 1'b1;
    end else if (clk_en_in) begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_out            = st_r.ack;
  assign wb_dat_out            = st_r.wb_rd;
  assign chip_sel_n_out        = st_r.cs_n;
  assign out_en_n_out          = st_r.oe_n;
  assign wr_strobe_n_out       = st_r.we_n;
  assign reset_powerdown_n_out = st_r.rst_pin;
  assign write_protect_n_out   = st_r.wp_pin;
  assign flash_addr_out        = st_r.addr;
  assign flash_dq_out          = st_r.bus_byte;
  assign flash_dq_oe_out       = st_r.dq_oe;
endmodule // flash_program_status_control
`default_nettype wire

// ### bench/flash_ctrl_checker.sv
`default_nettype none
module flash_ctrl_checker
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input wire logic              ref_clk_in,
  input wire logic              rst_b_in,
  // wishbone
  input wire logic              wb_cyc_in,
  input wire logic              wb_stb_in,
  input wire logic              wb_ack_out,
  // flash pins
  input wire logic              chip_sel_n_out,
  input wire logic              out_en_n_out,
  input wire logic              wr_strobe_n_out,
  input wire logic              reset_powerdown_n_out,
  input wire logic [ADDR_W-1:0] flash_addr_out,
  input wire logic [7:0]        flash_dq_out,
  input wire logic              flash_dq_oe_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
  write_qualify_a: assert property (!wr_strobe_n_out |-> !chip_sel_n_out && out_en_n_out)
    else $error("write strobe without select");
  dq_contention_a: assert property (flash_dq_oe_out |-> out_en_n_out) else $error("dq driven in read");
  write_width_a: assert property ($fell(wr_strobe_n_out) |-> (!wr_strobe_n_out)[*4] ##1 wr_strobe_n_out)
    else $error("write strobe width");
  write_hold_a: assert property (!wr_strobe_n_out && !$fell(wr_strobe_n_out)
    |-> $stable(flash_dq_out) && $stable(flash_addr_out)) else $error("write data moved");
  read_width_a: assert property ($fell(out_en_n_out)
    |-> (!out_en_n_out && !chip_sel_n_out)[*4] ##1 out_en_n_out) else $error("read strobe width");
  read_toggle_a: assert property ($rose(out_en_n_out) |-> (out_en_n_out && chip_sel_n_out)[*4])
    else $error("no toggle between reads");
  powerdown_idle_a: assert property (!reset_powerdown_n_out
    |=> chip_sel_n_out && out_en_n_out && wr_strobe_n_out) else $error("strobes active in power-down");
endmodule // flash_ctrl_checker
bind flash_program_status_control flash_ctrl_checker #(.ADDR_W(ADDR_W)) flash_ctrl_checker_inst (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_ack_out(wb_ack_out), .chip_sel_n_out(chip_sel_n_out), .out_en_n_out(out_en_n_out),
  .wr_strobe_n_out(wr_strobe_n_out), .reset_powerdown_n_out(reset_powerdown_n_out),
  .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out));
`default_nettype wire

// ### bench/flash_device_model.sv
`default_nettype none
module flash_device_model (
  // control pins, active low
  input wire logic        cs_n_in,
  input wire logic        oe_n_in,
  input wire logic        we_n_in,
  input wire logic        reset_powerdown_n_in,
  input wire logic        wp_n_in,
  // address and data
  input wire logic [17:0] addr_in,
  input wire logic [7:0]  dq_in,
  output logic [7:0]      dq_out,
  // comparator flags from the supply and pin voltage detectors
  input wire logic        supply_ok_in,
  input wire logic        below_lockout_in,
  input wire logic        unlock_high_voltage_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [int];
  logic [7:0] st = 8'h80; // no erase runs here, so suspend and erase error stay clear
  logic [7:0] lat = 8'h00;
  logic       status_mode = 1'b0;
  logic       setup = 1'b0;
  int         busy = 0;
  // released bus shows the inverse so a stale value never passes
  assign dq_out = (!cs_n_in && !oe_n_in && reset_powerdown_n_in) ? lat : ~lat;
  always @(negedge cs_n_in or negedge oe_n_in) begin
    if (!cs_n_in && !oe_n_in && reset_powerdown_n_in) begin
      lat = status_mode ? st : (mem.exists(int'(addr_in)) ? mem[int'(addr_in)] : 8'hFF);
      if (busy > 0) busy--;
      if (busy == 0) st[7] = 1'b1;
    end
  end
  always @(negedge reset_powerdown_n_in) begin
    st = 8'h80;
    status_mode = 1'b0;
    setup = 1'b0;
    busy = 0;
  end
  always @(posedge we_n_in) begin
    if (!cs_n_in && oe_n_in && reset_powerdown_n_in && !below_lockout_in) begin
      if (setup) begin
        setup = 1'b0;
        if (dq_in == 8'hFF) status_mode = 1'b0;
        else if (!supply_ok_in) st = st | 8'h18;
        else if (addr_in < 18'h0_4000 && !wp_n_in && !unlock_high_voltage_in) st = st | 8'h10;
        else begin
          mem[int'(addr_in)] = dq_in;
          st[7] = 1'b0;
          busy = 2;
        end
      end else if (st[5:3] == 3'b000 || dq_in inside {8'hFF, 8'h70, 8'h50}) begin
        case (dq_in)
          8'h40, 8'h10: begin
            setup = 1'b1;
            status_mode = 1'b1;
          end
          8'h70: status_mode = 1'b1;
          8'h50: st[5:3] = 3'b000;
          8'hFF: status_mode = 1'b0;
          default: setup = 1'b0;
        endcase
      end
    end
  end
endmodule // flash_device_model
`default_nettype wire

// ### bench/flash_program_status_control_test.sv
`default_nettype none
module flash_program_status_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_host_pkg::*;
  logic        below_lockout = 1'b0, unlock_high_voltage = 1'b0;
  logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, supply_ok = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic        ack, cs_n, oe_n, wr_n, reset_powerdown_n, wp_n, dq_oe;
  logic [17:0] faddr;
  logic [7:0]  dq_to_dev, dq_to_ctl;
  int          mismatches = 0, n_tests = 0;
  flash_program_status_control flash_program_status_control_inst (
    .ref_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .chip_sel_n_out(cs_n), .out_en_n_out(oe_n), .wr_strobe_n_out(wr_n), .reset_powerdown_n_out(reset_powerdown_n),
    .write_protect_n_out(wp_n), .flash_addr_out(faddr), .flash_dq_in(dq_to_ctl), .flash_dq_out(dq_to_dev),
    .flash_dq_oe_out(dq_oe));
  flash_device_model flash_device_model_inst (
    .cs_n_in(cs_n), .oe_n_in(oe_n), .we_n_in(wr_n), .reset_powerdown_n_in(reset_powerdown_n), .wp_n_in(wp_n),
    .addr_in(faddr), .dq_in(dq_to_dev), .dq_out(dq_to_ctl), .supply_ok_in(supply_ok),
    .below_lockout_in(below_lockout), .unlock_high_voltage_in(unlock_high_voltage));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // go, then poll the busy bit of the control register
  task automatic run(input logic [3:0] op, input logic wp);
    int n;
    n = 0;
    wb(1'b1, REG_CTRL, {25'h0, wp, 1'b1, 1'b1, op});
    do begin
      wb(1'b0, REG_CTRL, 32'h0000_0000);
      n++;
    end while (q[5] !== 1'b0 && n < 3000);
    chk("busy", 32'h0000_0000, {31'h0, q[5]});
  endtask
  task automatic prog(input logic [17:0] a, input logic [7:0] d, input logic wp);
    wb(1'b1, REG_ADDR, {14'h0, a});
    wb(1'b1, REG_DATA, {24'h0, d});
    run(OP_PROGRAM, wp);
  endtask
  task automatic st_is(input logic [9:0] e);
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("status", {22'h0, e}, {22'h0, q[9:0]});
  endtask
  task automatic rd_is(input logic [17:0] a, input logic [7:0] e);
    wb(1'b1, REG_ADDR, {14'h0, a});
    run(OP_READ, 1'b1);
    wb(1'b0, REG_DATA, 32'h0000_0000);
    chk("array", {24'h0, e}, {24'h0, q[7:0]});
  endtask
  task automatic t_program();
    prog(18'h1_2345, 8'h5A, 1'b1);
    st_is(10'h080);
    rd_is(18'h1_2345, 8'h5A);
    wb(1'b0, 4'h2, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
  endtask
  task automatic t_supply();
    supply_ok <= 1'b0;
    prog(18'h2_0000, 8'h11, 1'b1);
    st_is(10'h198);
    supply_ok <= 1'b1;
    prog(18'h2_0001, 8'h33, 1'b1);
    rd_is(18'h2_0001, 8'hFF);
    run(OP_STATUS, 1'b1);
    st_is(10'h198);
    below_lockout <= 1'b1;
    run(OP_CLEAR, 1'b1);
    below_lockout <= 1'b0;
    run(OP_STATUS, 1'b1);
    st_is(10'h198);
    run(OP_CLEAR, 1'b1);
    run(OP_STATUS, 1'b1);
    st_is(10'h080);
  endtask
  task automatic t_boot();
    prog(18'h0_0100, 8'h77, 1'b0);
    st_is(10'h190);
    run(OP_CLEAR, 1'b1);
    prog(18'h0_0100, 8'h77, 1'b1);
    rd_is(18'h0_0100, 8'h77);
    unlock_high_voltage <= 1'b1;
    prog(18'h0_0101, 8'h66, 1'b0);
    unlock_high_voltage <= 1'b0;
    rd_is(18'h0_0101, 8'h66);
  endtask
  task automatic t_abort();
    wb(1'b1, REG_ADDR, 32'h0000_0200);
    run(OP_ABORT, 1'b1);
    rd_is(18'h0_0200, 8'hFF);
    run(OP_STATUS, 1'b1);
    st_is(10'h080);
  endtask
  task automatic t_reset();
    supply_ok <= 1'b0;
    prog(18'h2_0002, 8'h22, 1'b1);
    supply_ok <= 1'b1;
    wb(1'b1, REG_CTRL, 32'h0000_0040);
    wb(1'b1, REG_CTRL, 32'h0000_0060);
    run(OP_STATUS, 1'b1);
    st_is(10'h080);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_program();
    t_supply();
    t_boot();
    t_abort();
    t_reset();
    stop_test();
  end
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    $display("mismatch watchdog expected done seen timeout");
    stop_test();
  end
endmodule // flash_program_status_control_test
`default_nettype wire
